// *** core/dorc_pkg.sv ***
package dorc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0]  ADDR_BRIDGE_MODE  = 2'h0;
  localparam logic [1:0]  ADDR_LAMP_MIRROR  = 2'h1;
  localparam logic [15:0] RST_BRIDGE_MODE   = 16'h0000;
  localparam logic [15:0] RST_LAMP_MIRROR   = 16'h0000;
  localparam logic [15:0] WMASK_BRIDGE_MODE = 16'hFFF1;
  localparam logic [15:0] WMASK_LAMP_MIRROR = 16'hFFFE;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_MODE           = 0;
  localparam int POS_BRIDGE_TOP     = 15;
  localparam int POS_LAMP7_UPPER    = 15;
  localparam int POS_LAMP8_UPPER    = 13;
  localparam int POS_LAMP9          = 11;
  localparam int POS_LAMP10         = 10;
  localparam int POS_LAMP11         = 9;
  localparam int POS_PULLDOWN       = 8;
  localparam int POS_DAC_LSB        = 2;
  localparam int POS_MIRROR_ENABLE  = 1;

  // ****************************************
  // Mirror reference scaling
  // ****************************************
  // 1.5 V full scale over 64 codes; 1.2 V limit is code 51 (1.195 V)
  localparam real        REF_FULL_SCALE_V = 1.5;
  localparam real        REF_CLAMP_V      = 1.2;
  localparam logic [5:0] REF_CLAMP_CODE   = 6'($rtoi(REF_CLAMP_V * 64.0 / REF_FULL_SCALE_V));

  // ****************************************
  // Carried groups
  // ****************************************
  typedef struct packed {
    logic [5:0] bridge_pwm_select;    // Index 0 is output 1
    logic [4:0] lamp_pwm_select;      // Index 0 is output 7
    logic       mirror_pulldown_pwm_select;
    logic       internal_pwm_enable;
    logic       full_scale_select;
  } dorc_pwm_cfg_t;

  typedef struct packed {
    logic [5:0] high_side_enable;
    logic [5:0] low_side_enable;
    logic [4:0] lamp_on;              // Index 0 is output 7
    logic [1:0] lamp_led_mode;
    logic       mirror_pulldown_enable;
    logic       pass_transistor_drive;
    logic [5:0] mirror_ref_code;
  } dorc_drive_t;

endpackage

// *** core/dorc_regs.sv ***
`timescale 1ns/1ns
module dorc_regs
  import dorc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register access from the serial frame decoder
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire logic [1:0]    reg_addr,
  input  wire logic [15:0]   wr_data,
  output logic      [15:0]   rd_data,
  // Settings held in the PWM control registers
  input  wire dorc_pwm_cfg_t pwm_cfg,
  // PWM sources
  input  wire logic          pwm_input_a,
  input  wire logic          pwm_input_b,
  input  wire logic          pwm_internal,
  // Driver controls
  output logic               active_mode,
  output dorc_drive_t        drive
);

  // ****************************************
  // Control registers
  // ****************************************
  logic [15:0] bridge_and_mode_control;
  logic [15:0] lamp_and_mirror_control;
  logic        standby_write;

  // A write with mode low wipes everything, including this same write's other bits
  assign standby_write = wr_en && reg_addr == ADDR_BRIDGE_MODE && !wr_data[POS_MODE];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bridge_and_mode_control <= RST_BRIDGE_MODE;
    end else if (standby_write) begin
      bridge_and_mode_control <= RST_BRIDGE_MODE;
    end else if (wr_en && reg_addr == ADDR_BRIDGE_MODE) begin
      bridge_and_mode_control <= wr_data & WMASK_BRIDGE_MODE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_and_mirror_control <= RST_LAMP_MIRROR;
    end else if (standby_write) begin
      lamp_and_mirror_control <= RST_LAMP_MIRROR;
    end else if (wr_en && reg_addr == ADDR_LAMP_MIRROR) begin
      lamp_and_mirror_control <= wr_data & WMASK_LAMP_MIRROR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      unique case (reg_addr)
        ADDR_BRIDGE_MODE: rd_data <= bridge_and_mode_control;
        ADDR_LAMP_MIRROR: rd_data <= lamp_and_mirror_control;
        default:          rd_data <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Output decode
  // ****************************************
  logic              mode_bit;
  logic [5:0]        next_high;
  logic [5:0]        next_low;
  logic [5:0]        bridge_gate;
  logic [4:0]        lamp_enable;
  logic [4:0]        lamp_source;
  logic [4:0]        next_lamp_on;
  logic [1:0]        next_led_mode;
  logic [5:0]        dac_code;
  logic              mirror_en;
  logic              next_pulldown;
  logic [5:0]        next_ref_code;

  assign mode_bit  = bridge_and_mode_control[POS_MODE];
  assign dac_code  = lamp_and_mirror_control[POS_DAC_LSB +: 6];
  assign mirror_en = lamp_and_mirror_control[POS_MIRROR_ENABLE];

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_bridge
      logic hs_bit;
      logic ls_bit;
      assign hs_bit = bridge_and_mode_control[POS_BRIDGE_TOP - 2 * i];
      assign ls_bit = bridge_and_mode_control[POS_BRIDGE_TOP - 2 * i - 1];
      // Output 5 gates on the second pin
      assign bridge_gate[i] = !pwm_cfg.bridge_pwm_select[i] ||
                              ((i == 4) ? pwm_input_b : pwm_input_a);
      // Mismatched pair only; 00 and 11 both leave the output floating
      assign next_high[i] = mode_bit && hs_bit && !ls_bit && bridge_gate[i];
      assign next_low[i]  = mode_bit && ls_bit && !hs_bit && bridge_gate[i];
    end
  endgenerate

  // Lamp enables: 7 and 8 take a two-bit mode field, 10 is forced by the mirror
  always_comb begin
    lamp_enable[0] = ^lamp_and_mirror_control[POS_LAMP7_UPPER -: 2];
    lamp_enable[1] = ^lamp_and_mirror_control[POS_LAMP8_UPPER -: 2];
    lamp_enable[2] = lamp_and_mirror_control[POS_LAMP9];
    lamp_enable[3] = lamp_and_mirror_control[POS_LAMP10] || mirror_en;
    lamp_enable[4] = lamp_and_mirror_control[POS_LAMP11];
    next_led_mode  = {lamp_and_mirror_control[POS_LAMP8_UPPER -: 2] == 2'b01,
                      lamp_and_mirror_control[POS_LAMP7_UPPER -: 2] == 2'b01};
  end

  // Internal generator replaces the pin for 7 to 10 only; 11 has no internal route
  always_comb begin
    lamp_source[0] = pwm_cfg.internal_pwm_enable ? pwm_internal : pwm_input_a;
    lamp_source[1] = pwm_cfg.internal_pwm_enable ? pwm_internal : pwm_input_b;
    lamp_source[2] = pwm_cfg.internal_pwm_enable ? pwm_internal : pwm_input_a;
    lamp_source[3] = pwm_cfg.internal_pwm_enable ? pwm_internal : pwm_input_b;
    lamp_source[4] = pwm_input_a;
  end

  generate
    for (i = 0; i < 5; i++) begin : g_lamp
      assign next_lamp_on[i] = mode_bit && lamp_enable[i] &&
                               (!pwm_cfg.lamp_pwm_select[i] || lamp_source[i]);
    end
  endgenerate

  assign next_pulldown = mode_bit && lamp_and_mirror_control[POS_PULLDOWN] &&
                         dac_code == 6'h00 &&
                         (!pwm_cfg.mirror_pulldown_pwm_select || pwm_input_a);

  // Clamp in code space keeps the analog side a plain 1.5 V full-scale converter
  assign next_ref_code = (!pwm_cfg.full_scale_select && dac_code > REF_CLAMP_CODE) ?
                         REF_CLAMP_CODE : dac_code;

  // ****************************************
  // Registered drive outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_mode <= 1'b0;
      drive       <= '0;
    end else begin
      active_mode                  <= mode_bit;
      drive.high_side_enable       <= next_high;
      drive.low_side_enable        <= next_low;
      drive.lamp_on                <= next_lamp_on;
      drive.lamp_led_mode          <= mode_bit ? next_led_mode : 2'b00;
      drive.mirror_pulldown_enable <= next_pulldown;
      drive.pass_transistor_drive  <= mode_bit && mirror_en;
      drive.mirror_ref_code        <= mode_bit ? next_ref_code : 6'h00;
    end
  end

endmodule

// *** verif/dorc_host.sv ***
`timescale 1ns/1ns
module dorc_host (
  // Register port, host side
  input  wire logic   clk,
  input  wire logic [15:0] rd_data,
  output logic        wr_en, rd_en,
  output logic [1:0]  reg_addr,
  output logic [15:0] wr_data
);
  initial begin
    wr_en = 1'b0; rd_en = 1'b0; reg_addr = 2'h0; wr_data = 16'h0000;
  end
  // Idle data inverted so a stale word never looks valid
  task automatic access(input logic w, input logic [1:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    wr_en <= w; rd_en <= !w; reg_addr <= a; wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0; rd_en <= 1'b0; wr_data <= ~d;
    @(posedge clk);
    q = rd_data;
  endtask
endmodule

// *** verif/dorc_regs_checker.sv ***
`timescale 1ns/1ns
module dorc_regs_checker
  import dorc_pkg::*;
(
  // Clock, reset and register port
  input wire logic          clk, rst_n, wr_en, rd_en,
  input wire logic [1:0]    reg_addr,
  input wire logic [15:0]   wr_data, rd_data,
  // PWM and drive side
  input wire dorc_pwm_cfg_t pwm_cfg,
  input wire logic          pwm_input_a, pwm_input_b, pwm_internal, active_mode,
  input wire dorc_drive_t   drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_no_shoot; (drive.high_side_enable & drive.low_side_enable) == 6'h00; endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both switches on");
  property p_b5_gate; $past(pwm_cfg.bridge_pwm_select[4]) && !$past(pwm_input_b)
    |-> !drive.high_side_enable[4] && !drive.low_side_enable[4]; endproperty
  a_b5_gate: assert property (p_b5_gate) else $error("bridge 5 on with pin low");
  // Mode seen two edges after the write
  property p_mode; wr_en && reg_addr == 2'h0 |-> ##2 active_mode == $past(wr_data[0], 2); endproperty
  a_mode: assert property (p_mode) else $error("mode not taken");
  property p_standby; !active_mode |-> drive == '0; endproperty
  a_standby: assert property (p_standby) else $error("drive in standby");
  property p_lamp8; $past(pwm_cfg.lamp_pwm_select[1]) && !$past(pwm_cfg.internal_pwm_enable)
    && !$past(pwm_input_b) |-> !drive.lamp_on[1]; endproperty
  a_lamp8: assert property (p_lamp8) else $error("lamp 8 on with pin low");
  property p_force10; drive.pass_transistor_drive && !$past(pwm_cfg.lamp_pwm_select[3])
    |-> drive.lamp_on[3]; endproperty
  a_force10: assert property (p_force10) else $error("output 10 not forced");
  property p_pd_code; drive.mirror_pulldown_enable |-> drive.mirror_ref_code == 6'h00; endproperty
  a_pd_code: assert property (p_pd_code) else $error("pull-down with code");
  property p_pd_pwm; drive.mirror_pulldown_enable && $past(pwm_cfg.mirror_pulldown_pwm_select)
    |-> $past(pwm_input_a); endproperty
  a_pd_pwm: assert property (p_pd_pwm) else $error("pull-down with pin low");
  property p_clamp; !$past(pwm_cfg.full_scale_select) |-> drive.mirror_ref_code <= 6'h33; endproperty
  a_clamp: assert property (p_clamp) else $error("code above clamp");
  property p_rsvd; rd_en |=> (rd_data & ~(($past(reg_addr) == 2'h0) ? 16'hFFF1 :
    ($past(reg_addr) == 2'h1) ? 16'hFFFE : 16'h0000)) == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("unassigned bit read set");
endmodule
bind dorc_regs dorc_regs_checker u_chk (.clk, .rst_n, .wr_en, .rd_en, .reg_addr, .wr_data, .rd_data,
  .pwm_cfg, .pwm_input_a, .pwm_input_b, .pwm_internal, .active_mode, .drive);

// *** verif/dorc_regs_tb.sv ***
`timescale 1ns/1ns
module dorc_regs_tb;
  import dorc_pkg::*;
  logic          clk = 1'b0, rst_n = 1'b0, pa = 1'b0, pb = 1'b0, pi = 1'b0, wr_en, rd_en, act;
  logic [1:0]    addr;
  logic [15:0]   wd, rd, q, r0, r1;
  dorc_pwm_cfg_t cfg = '0;
  dorc_drive_t   drv;
  int            errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  dorc_regs dut (.clk, .rst_n, .wr_en, .rd_en, .reg_addr(addr), .wr_data(wd), .rd_data(rd), .pwm_cfg(cfg),
    .pwm_input_a(pa), .pwm_input_b(pb), .pwm_internal(pi), .active_mode(act), .drive(drv));
  dorc_host host (.clk, .rd_data(rd), .wr_en, .rd_en, .reg_addr(addr), .wr_data(wd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic dorc_drive_t exp_drv(logic [15:0] c0, logic [15:0] c1, dorc_pwm_cfg_t c, logic a, logic b,
    logic i);
    dorc_drive_t e;
    logic [4:0]  en;
    logic        s;
    e = '0;
    for (int k = 0; k < 6; k++) begin
      s = !c.bridge_pwm_select[k] || (k == 4 ? b : a);
      e.high_side_enable[k] = c0[15-2*k] & !c0[14-2*k] & s;
      e.low_side_enable[k] = c0[14-2*k] & !c0[15-2*k] & s;
    end
    en = {c1[9], c1[10] | c1[1], c1[11], ^c1[13:12], ^c1[15:14]};
    for (int k = 0; k < 5; k++) begin
      s = (k < 4 && c.internal_pwm_enable) ? i : (k == 1 || k == 3) ? b : a;
      e.lamp_on[k] = en[k] & (!c.lamp_pwm_select[k] | s);
    end
    e.lamp_led_mode = {c1[13:12] == 2'b01, c1[15:14] == 2'b01};
    e.mirror_pulldown_enable = c1[8] & (c1[7:2] == 6'h00) & (!c.mirror_pulldown_pwm_select | a);
    e.pass_transistor_drive = c1[1];
    e.mirror_ref_code = (!c.full_scale_select && c1[7:2] > 6'h33) ? 6'h33 : c1[7:2];
    if (!c0[0]) e = '0;
    return e;
  endfunction
  initial begin
    void'($urandom(32'hFA83));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      host.access(1'b0, 2'(a), 16'h0000, q);
      check(q, 16'h0000);
    end
    for (int a = 0; a < 3; a++) host.access(1'b1, 2'(a), 16'hFFFF, q);
    host.access(1'b0, 2'h0, 16'h0000, q);
    check(q, 16'hFFF1);
    host.access(1'b0, 2'h1, 16'h0000, q);
    check(q, 16'hFFFE);
    host.access(1'b0, 2'h2, 16'h0000, q);
    check(q, 16'h0000);
    check(act, 1'b1);
    check(drv, exp_drv(16'hFFF1, 16'hFFFE, cfg, pa, pb, pi));
    // Random images, one in four with a zero mirror code to open the pull-down
    repeat (60) begin
      r0 = 16'($urandom) | 16'h0001;
      r1 = 16'($urandom);
      if ($urandom_range(0, 3) == 0) r1[7:2] = 6'h00;
      host.access(1'b1, 2'h0, r0, q);
      host.access(1'b1, 2'h1, r1, q);
      @(posedge clk);
      cfg <= dorc_pwm_cfg_t'(14'($urandom)); pa <= 1'($urandom); pb <= 1'($urandom); pi <= 1'($urandom);
      repeat (2) @(posedge clk);
      check(drv, exp_drv(r0 & 16'hFFF1, r1 & 16'hFFFE, cfg, pa, pb, pi));
    end
    host.access(1'b1, 2'h0, 16'hAAA0, q);
    repeat (2) @(posedge clk);
    check(act, 1'b0);
    check(drv, 27'h0);
    for (int a = 0; a < 2; a++) begin
      host.access(1'b0, 2'(a), 16'h0000, q);
      check(q, 16'h0000);
    end
    // Mid-run reset must wipe a live image
    host.access(1'b1, 2'h0, 16'h8001, q);
    host.access(1'b1, 2'h1, 16'h0402, q);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(act, 1'b0);
    check(drv, 27'h0);
    rst_n <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      host.access(1'b0, 2'(a), 16'h0000, q);
      check(q, 16'h0000);
    end
    wrap_up();
  end
  initial begin
    #300000;
    errors++;
    wrap_up();
  end
endmodule
